/* File: verilog/sfsp_params.svh */
`ifndef SFSP_PARAMS_SVH
`define SFSP_PARAMS_SVH
// Opcodes that execute.
`define SF_OP_WREN   8'h06
`define SF_OP_WRR    8'h01
`define SF_OP_WRAR   8'h71
`define SF_OP_CLSR   8'h30
`define SF_OP_PP     8'h02
`define SF_OP_SE     8'hD8
`define SF_OP_P4E    8'h20
`define SF_OP_OTPP   8'h42
`define SF_OP_EES    8'hD0
`define SF_OP_DPD    8'hB9
`define SF_OP_RES    8'hAB
// Legacy opcodes that are refused.
`define SF_OP_ABRD   8'h14
`define SF_OP_ABWR   8'h15
`define SF_OP_BRRD   8'h16
`define SF_OP_BRWR   8'h17
`define SF_OP_DOR    8'h3B
`define SF_OP_QOR    8'h6B
`define SF_OP_QPP    8'h32
`define SF_OP_DDRFR  8'h0D
`define SF_OP_DDRDIO 8'hBD
// Register addresses for the any-register write.
`define SF_RA_NONVOLATILE_CONFIG_REG1  32'h0000_0002
`define SF_RA_VOLATILE_CONFIG_REG1   32'h0080_0002
`define SF_RA_VOLATILE_CONFIG_REG2   32'h0080_0003
`define SF_RA_ASP    32'h0000_0030
// Status register 1 bits.
`define SF_WIP       0
`define SF_WEL       1
`define SF_EERR      5
`define SF_PERR      6
`define SF_BP_MSK    8'h1C
// Configuration register 1 bits.
`define SF_FRZ       0
`define SF_QUAD      1
`define SF_TBPARM    2
`define SF_CR1_OTP   8'h2C
// Configuration register 2 bits.
`define SF_IO3R      5
`define SF_QPI       6
`define SF_LAT_MSK   8'h0F
// Advanced protection register bits.
`define SF_ASP_MSK   8'h0E
`define SF_ASP_PERM  3
// Reset values.
`define SF_NONVOLATILE_STATUS_REG1_RST 8'h00
`define SF_NONVOLATILE_CONFIG_REG1_RST 8'h00
`define SF_VOLATILE_CONFIG_REG2_RST  8'h08
`define SF_ASP_RST   8'h00
// Link capture depth in bits and the parameter region span.
`define SF_LBITS     6'd48
`define SF_PAR_LSB   15
`endif

/* File: verilog/sfsp_pkg.sv */
package sfsp_pkg;
  typedef enum logic [1:0] {
    SF_IDLE = 2'b00,
    SF_BUSY = 2'b01,
    SF_DPD  = 2'b10
  } sfsp_st_type;
  typedef enum logic [2:0] {
    SF_K_PROG  = 3'b000,
    SF_K_OTP   = 3'b001,
    SF_K_ERASE = 3'b010,
    SF_K_ER4K  = 3'b011,
    SF_K_EVAL  = 3'b100
  } sfsp_op_type;
  typedef struct packed {
    logic [47:0] sh;
    logic [5:0]  cnt;
    logic        tog;
  } sfsp_link_type;
  typedef struct packed {
    sfsp_st_type st;
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_d;
    logic        io3_s1;
    logic        io3_s2;
    logic        io3_d;
    logic        tg_s1;
    logic        tg_s2;
    logic        tg_seen;
    logic [7:0]  volatile_status_reg1;
    logic [7:0]  nonvolatile_status_reg1;
    logic [7:0]  volatile_config_reg1;
    logic [7:0]  nonvolatile_config_reg1;
    logic [7:0]  volatile_config_reg2;
    logic [7:0]  advanced_sector_protection;
    logic        ees_ok;
    logic        op_start;
    sfsp_op_type kind;
    logic [31:0] addr;
    logic [7:0]  data;
    logic        refused;
    logic        hw_rst;
  } sfsp_core_type;
endpackage : sfsp_pkg

/* File: verilog/sfsp_ctrl.sv */
`timescale 1ns/1ps
`include "sfsp_params.svh"
module sfsp_ctrl #(
  parameter int ADDR_W = 26
) (
  // Clocks and reset
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  sck,
  // Serial pins
  input  wire logic                  cs_n,
  input  wire logic [3:0]            io_in,
  // Array engine
  output logic                       op_start,
  output sfsp_pkg::sfsp_op_type      op_kind,
  output logic [31:0]                op_addr,
  output logic [7:0]                 op_data,
  input  wire logic                  op_done,
  input  wire logic                  op_fail,
  input  wire logic                  sect_prot,
  // Status and configuration
  output logic [7:0]                 status_reg1,
  output logic [7:0]                 config_reg1,
  output logic [7:0]                 config_reg2,
  output logic [3:0]                 read_latency,
  output logic                       quad_mode,
  output logic                       four_bit_mode,
  output logic                       ppb_perm_lock,
  output logic                       ees_ok,
  output logic                       dpd_active,
  output logic                       cmd_refused,
  output logic                       hw_reset
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 16 || ADDR_W > 32)
  begin : g_bad
    $error("ADDR_W must lie between 16 and 32.");
  end

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  sfsp_pkg::sfsp_link_type lq;
  sfsp_pkg::sfsp_link_type nxt_lq;
  sfsp_pkg::sfsp_core_type q;
  sfsp_pkg::sfsp_core_type n;
  logic                    fa_ff;
  logic                    lrst_n;

  // Frame-active flag; select high clears it, so no sck edge is needed.
  assign lrst_n = arst_n & ~cs_n;
  always_ff @(posedge sck or negedge lrst_n)
  begin
    if (!lrst_n)
      fa_ff <= 1'b0;
    else
      fa_ff <= 1'b1;
  end

  // Shift in one bit, or a nibble in four-bit mode. Mode bits are only
  // written after a frame ends, so they are static while sck runs.
  always_comb
  begin
    logic [5:0] base;
    logic [3:0] nib;
    base   = fa_ff ? lq.cnt : 6'h00;
    nib    = {q.volatile_config_reg1[`SF_QUAD] & io_in[3], io_in[2:0]};
    nxt_lq = lq;
    if (!fa_ff)
      nxt_lq.tog = ~lq.tog;
    nxt_lq.cnt = base;
    if (base != `SF_LBITS)
    begin
      if (q.volatile_config_reg2[`SF_QPI])
      begin
        nxt_lq.sh  = {lq.sh[43:0], nib};
        nxt_lq.cnt = base + 6'd4;
      end
      else
      begin
        nxt_lq.sh  = {lq.sh[46:0], io_in[0]};
        nxt_lq.cnt = base + 6'd1;
      end
    end
  end

  // Link registers.
  always_ff @(posedge sck or negedge arst_n)
  begin
    if (!arst_n)
      lq <= '0;
    else
      lq <= nxt_lq;
  end

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  logic [47:0] al;
  logic [7:0]  opc;
  logic [31:0] adr;
  logic [2:0]  nb;
  logic        rise;
  logic        go;
  logic        trig;
  logic        err;
  logic        wr_ok;
  logic        alock;
  logic        par;
  logic        par_q;
  logic        legacy;

  // The frame is read only after select rises, when sck stands still.
  assign al     = lq.sh << (`SF_LBITS - lq.cnt);
  assign opc    = al[47:40];
  assign adr    = al[39:8];
  assign nb     = lq.cnt[5:3];
  assign rise   = q.cs_s2 & ~q.cs_d;
  assign go     = rise && (q.tg_s2 != q.tg_seen) && lq.cnt[2:0] == 3'h0 && nb != 3'h0;
  assign err    = q.volatile_status_reg1[`SF_EERR] | q.volatile_status_reg1[`SF_PERR];
  assign wr_ok  = q.volatile_status_reg1[`SF_WEL] & ~err;
  assign alock  = q.advanced_sector_protection[1] | q.advanced_sector_protection[2];
  // Parameter sectors sit at the bottom or the top of the space.
  assign par    = q.nonvolatile_config_reg1[`SF_TBPARM] ? &adr[ADDR_W-1:`SF_PAR_LSB] : ~|adr[ADDR_W-1:`SF_PAR_LSB];
  assign par_q  = q.nonvolatile_config_reg1[`SF_TBPARM] ? &q.addr[ADDR_W-1:`SF_PAR_LSB] : ~|q.addr[ADDR_W-1:`SF_PAR_LSB];
  assign legacy = opc == `SF_OP_ABRD || opc == `SF_OP_ABWR || opc == `SF_OP_BRRD
               || opc == `SF_OP_BRWR || opc == `SF_OP_DOR || opc == `SF_OP_QOR
               || opc == `SF_OP_QPP || opc == `SF_OP_DDRFR || opc == `SF_OP_DDRDIO;
  // Reset pin: enabled by IO3R, and acts only with select high, in or out of quad mode.
  assign trig   = q.volatile_config_reg2[`SF_IO3R] && (!q.volatile_config_reg1[`SF_QUAD] || q.cs_s2)
               && q.cs_s2 && q.io3_d && !q.io3_s2;

  // ----------------------------------------------------------------
  // Core sequencer
  // ----------------------------------------------------------------
  // Commands run once per frame, at the synchronised select rise.
  always_comb
  begin
    n          = q;
    n.cs_s1    = cs_n;
    n.cs_s2    = q.cs_s1;
    n.cs_d     = q.cs_s2;
    n.io3_s1   = io_in[3];
    n.io3_s2   = q.io3_s1;
    n.io3_d    = q.io3_s2;
    n.tg_s1    = lq.tog;
    n.tg_s2    = q.tg_s1;
    n.op_start = 1'b0;
    n.refused  = 1'b0;
    n.hw_rst   = 1'b0;
    if (rise)
      n.tg_seen = q.tg_s2;
    case (q.st)
      sfsp_pkg::SF_IDLE:
      begin
        if (go)
        begin
          n.addr = adr;
          n.data = al[7:0];
          case (opc)
            `SF_OP_WREN:
              n.volatile_status_reg1[`SF_WEL] = 1'b1;
            `SF_OP_CLSR:
            begin
              n.volatile_status_reg1[`SF_EERR] = 1'b0;
              n.volatile_status_reg1[`SF_PERR] = 1'b0;
              n.volatile_status_reg1[`SF_WIP]  = 1'b0;
            end
            `SF_OP_WRR:
            begin
              if (wr_ok && nb >= 3'd2)
              begin
                n.volatile_status_reg1[`SF_WEL] = 1'b0;
                if (!q.volatile_config_reg1[`SF_FRZ])
                begin
                  n.volatile_status_reg1  = (q.volatile_status_reg1 & ~`SF_BP_MSK) | (al[39:32] & `SF_BP_MSK);
                  n.nonvolatile_status_reg1 = (q.nonvolatile_status_reg1 & ~`SF_BP_MSK) | (al[39:32] & `SF_BP_MSK);
                end
                // A lone status byte must not touch config.
                if (nb >= 3'd3)
                begin
                  n.volatile_config_reg1[`SF_QUAD] = al[`SF_QUAD+24];
                  n.volatile_config_reg1[`SF_FRZ]  = q.volatile_config_reg1[`SF_FRZ] | al[24];
                  if (!q.volatile_config_reg1[`SF_FRZ] && !alock)
                    n.nonvolatile_config_reg1 = q.nonvolatile_config_reg1 | (al[31:24] & `SF_CR1_OTP);
                  n.volatile_config_reg1 = (n.volatile_config_reg1 & ~`SF_CR1_OTP) | (n.nonvolatile_config_reg1 & `SF_CR1_OTP);
                end
              end
            end
            `SF_OP_WRAR:
            begin
              if (wr_ok && nb == 3'd6)
              begin
                n.volatile_status_reg1[`SF_WEL] = 1'b0;
                case (adr)
                  `SF_RA_VOLATILE_CONFIG_REG2:
                    n.volatile_config_reg2 = al[7:0];
                  `SF_RA_VOLATILE_CONFIG_REG1:
                  begin
                    n.volatile_config_reg1[`SF_QUAD] = al[`SF_QUAD];
                    n.volatile_config_reg1[`SF_FRZ]  = q.volatile_config_reg1[`SF_FRZ] | al[0];
                  end
                  `SF_RA_NONVOLATILE_CONFIG_REG1:
                  begin
                    if (!q.volatile_config_reg1[`SF_FRZ] && !alock)
                      n.nonvolatile_config_reg1 = q.nonvolatile_config_reg1 | (al[7:0] & `SF_CR1_OTP);
                    n.volatile_config_reg1 = (q.volatile_config_reg1 & ~`SF_CR1_OTP) | (n.nonvolatile_config_reg1 & `SF_CR1_OTP);
                  end
                  `SF_RA_ASP:
                    if (!alock)
                      n.advanced_sector_protection = q.advanced_sector_protection | (al[7:0] & `SF_ASP_MSK);
                  default:
                    n.volatile_status_reg1[`SF_WEL] = 1'b0;
                endcase
              end
            end
            `SF_OP_PP, `SF_OP_OTPP, `SF_OP_SE, `SF_OP_P4E:
            begin
              n.kind = (opc == `SF_OP_PP) ? sfsp_pkg::SF_K_PROG :
                       (opc == `SF_OP_OTPP) ? sfsp_pkg::SF_K_OTP :
                       (opc == `SF_OP_SE) ? sfsp_pkg::SF_K_ERASE : sfsp_pkg::SF_K_ER4K;
              if (wr_ok && (opc != `SF_OP_P4E || par))
              begin
                n.volatile_status_reg1[`SF_WIP] = 1'b1;
                // OTP region answers to freeze as well as to sector protection.
                if (sect_prot || (opc == `SF_OP_OTPP && q.volatile_config_reg1[`SF_FRZ]))
                begin
                  if (opc == `SF_OP_PP || opc == `SF_OP_OTPP)
                    n.volatile_status_reg1[`SF_PERR] = 1'b1;
                  else
                    n.volatile_status_reg1[`SF_EERR] = 1'b1;
                end
                else
                begin
                  n.op_start = 1'b1;
                  n.st       = sfsp_pkg::SF_BUSY;
                end
              end
            end
            `SF_OP_EES:
            begin
              n.kind          = sfsp_pkg::SF_K_EVAL;
              n.volatile_status_reg1[`SF_WIP] = 1'b1;
              n.op_start      = 1'b1;
              n.st            = sfsp_pkg::SF_BUSY;
            end
            `SF_OP_DPD:
              n.st = sfsp_pkg::SF_DPD;
            default:
              n.refused = legacy;
          endcase
        end
      end
      sfsp_pkg::SF_BUSY:
      begin
        if (op_done)
        begin
          n.st = sfsp_pkg::SF_IDLE;
          if (q.kind == sfsp_pkg::SF_K_EVAL)
          begin
            n.ees_ok        = ~op_fail;
            // An evaluation run under a standing error must not drop busy.
            n.volatile_status_reg1[`SF_WIP] = err;
          end
          else if (op_fail)
          begin
            // Busy stays high until clear-status or a pin reset.
            if (q.kind == sfsp_pkg::SF_K_PROG || q.kind == sfsp_pkg::SF_K_OTP)
              n.volatile_status_reg1[`SF_PERR] = 1'b1;
            else
              n.volatile_status_reg1[`SF_EERR] = 1'b1;
          end
          else
          begin
            n.volatile_status_reg1[`SF_WIP] = 1'b0;
            n.volatile_status_reg1[`SF_WEL] = 1'b0;
          end
        end
      end
      sfsp_pkg::SF_DPD:
      begin
        if (go && opc == `SF_OP_RES)
          n.st = sfsp_pkg::SF_IDLE;
      end
      default:
        n.st = sfsp_pkg::SF_IDLE;
    endcase
    // Pin reset reloads volatile state and abandons any operation.
    if (trig)
    begin
      n.st       = sfsp_pkg::SF_IDLE;
      n.volatile_status_reg1     = q.nonvolatile_status_reg1 & `SF_BP_MSK;
      n.volatile_config_reg1     = q.nonvolatile_config_reg1 & `SF_CR1_OTP;
      n.volatile_config_reg2     = `SF_VOLATILE_CONFIG_REG2_RST;
      n.op_start = 1'b0;
      n.hw_rst   = 1'b1;
    end
  end

  // Core registers.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q       <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.cs_d  <= 1'b1;
      q.io3_s1 <= 1'b1;
      q.io3_s2 <= 1'b1;
      q.io3_d <= 1'b1;
      q.nonvolatile_status_reg1 <= `SF_NONVOLATILE_STATUS_REG1_RST;
      q.volatile_status_reg1  <= `SF_NONVOLATILE_STATUS_REG1_RST & `SF_BP_MSK;
      q.nonvolatile_config_reg1 <= `SF_NONVOLATILE_CONFIG_REG1_RST;
      q.volatile_config_reg1  <= `SF_NONVOLATILE_CONFIG_REG1_RST & `SF_CR1_OTP;
      q.volatile_config_reg2  <= `SF_VOLATILE_CONFIG_REG2_RST;
      q.advanced_sector_protection   <= `SF_ASP_RST;
    end
    else
      q <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign op_start      = q.op_start;
  assign op_kind       = q.kind;
  assign op_addr       = q.addr;
  assign op_data       = q.data;
  assign status_reg1   = q.volatile_status_reg1;
  assign config_reg1   = q.volatile_config_reg1;
  assign config_reg2   = q.volatile_config_reg2;
  assign read_latency  = q.volatile_config_reg2[3:0];
  assign quad_mode     = q.volatile_config_reg1[`SF_QUAD];
  assign four_bit_mode = q.volatile_config_reg2[`SF_QPI];
  assign ppb_perm_lock = q.advanced_sector_protection[`SF_ASP_PERM];
  assign ees_ok        = q.ees_ok;
  assign dpd_active    = q.st == sfsp_pkg::SF_DPD;
  assign cmd_refused   = q.refused;
  assign hw_reset      = q.hw_rst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_fail;
    q.st == sfsp_pkg::SF_BUSY && op_done && op_fail && !trig && q.kind != sfsp_pkg::SF_K_EVAL;
  endsequence
  sequence s_pin_low;
    q.volatile_config_reg2[`SF_IO3R] && q.cs_s2 && q.io3_d ##0 !q.io3_s2;
  endsequence
  sequence s_idle_go;
    q.st == sfsp_pkg::SF_IDLE && go && !trig;
  endsequence

  a_err_holds_wip: assert property (
    err |-> q.volatile_status_reg1[`SF_WIP]) else $error("Error flag without busy flag.");
  a_fail_sets_err: assert property (
    s_fail |=> err) else $error("Failure did not raise an error flag.");
  a_fail_not_done: assert property (
    s_fail |=> q.volatile_status_reg1[`SF_WIP] && !q.op_start) else $error("Failed operation reported done.");
  a_clsr_clears: assert property (
    s_idle_go ##0 opc == `SF_OP_CLSR |=> !err && !q.volatile_status_reg1[`SF_WIP]) else $error("Clear-status failed.");
  a_freeze_bp: assert property (
    q.volatile_config_reg1[`SF_FRZ] && !trig |=> $stable(q.volatile_status_reg1[4:2])) else $error("Protect bits moved while frozen.");
  a_freeze_otp: assert property (
    q.volatile_config_reg1[`SF_FRZ] && !trig |=> $stable(q.nonvolatile_config_reg1) && !(q.op_start && q.kind == sfsp_pkg::SF_K_OTP))
    else $error("OTP setting changed while frozen.");
  a_p4e_param: assert property (
    q.op_start && q.kind == sfsp_pkg::SF_K_ER4K |-> par_q) else $error("Small erase off parameter area.");
  a_wrr_single: assert property (
    s_idle_go ##0 opc == `SF_OP_WRR && nb == 3'd2 |=> $stable(q.volatile_config_reg1)) else $error("One byte write hit config.");
  a_shared_pin_a: assert property (
    s_pin_low ##0 !q.volatile_config_reg1[`SF_QUAD] |=> q.hw_rst && q.st == sfsp_pkg::SF_IDLE) else $error("Pin reset missed.");
  a_legacy_ref: assert property (
    s_idle_go ##0 legacy |=> q.refused && !q.op_start) else $error("Legacy command not refused.");
  a_ees_result: assert property (
    q.st == sfsp_pkg::SF_BUSY && q.kind == sfsp_pkg::SF_K_EVAL && op_done && !trig
    |=> q.ees_ok == !$past(op_fail)) else $error("Erase status wrong.");
  a_asp_lock: assert property (
    alock |=> $stable(q.advanced_sector_protection) && $stable(q.nonvolatile_config_reg1)) else $error("OTP config changed after lock.");
  a_dpd_stay: assert property (
    q.st == sfsp_pkg::SF_DPD && !trig && !(go && opc == `SF_OP_RES) |=> q.st == sfsp_pkg::SF_DPD)
    else $error("Left deep power-down early.");
  a_err_block: assert property (
    err && !(go && opc == `SF_OP_EES) |=> !q.op_start) else $error("Operation started under error.");

endmodule : sfsp_ctrl

/* File: bench/sfsp_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------------
module sfsp_host (
  // Link pins
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in
);
  // Clock idles low between frames; the pull-ups hold IO2 and IO3 high.
  initial
  begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'hF;
  end

  // One frame, MSB first, in 12 ns clock periods; wide sends nibbles.
  task automatic frame(input logic [47:0] bits, input int nbytes, input bit wide);
    int i;
    cs_n = 1'b0;
    for (i = 0; i < nbytes * 8; i += (wide ? 4 : 1))
    begin
      io_in = wide ? bits[47 - i -: 4] : {3'b111, bits[47 - i]};
      #6 sck = 1'b1;
      #6 sck = 1'b0;
    end
    #6 cs_n = 1'b1;
    // A released data line must not keep showing its last value.
    io_in = {3'b111, ~io_in[0]};
  endtask : frame

  // Pull the shared reset pin low with select high.
  task automatic pin_reset();
    io_in[3] = 1'b0;
    #200 io_in[3] = 1'b1;
  endtask : pin_reset
endmodule : sfsp_host

/* File: bench/spi_flash_status_protect_logic_tb.sv */
`timescale 1ns/1ps
module spi_flash_status_protect_logic_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic                  ref_clk, arst_n, sck, cs_n, op_done, op_fail, sect_prot;
  logic [3:0]            io_in, read_latency;
  logic                  op_start, quad_mode, four_bit_mode, ppb_perm_lock;
  logic                  ees_ok, dpd_active, cmd_refused, hw_reset;
  sfsp_pkg::sfsp_op_type op_kind;
  logic [31:0]           op_addr;
  logic [7:0]            op_data, status_reg1, config_reg1, config_reg2;
  int                    mismatches, n_compared, n_start, n_ref, n_hw, i;

  sfsp_host host (.sck(sck), .cs_n(cs_n), .io_in(io_in));
  sfsp_ctrl uut (.ref_clk(ref_clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .io_in(io_in),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
    .op_done(op_done), .op_fail(op_fail), .sect_prot(sect_prot), .status_reg1(status_reg1),
    .config_reg1(config_reg1), .config_reg2(config_reg2), .read_latency(read_latency),
    .quad_mode(quad_mode), .four_bit_mode(four_bit_mode), .ppb_perm_lock(ppb_perm_lock),
    .ees_ok(ees_ok), .dpd_active(dpd_active), .cmd_refused(cmd_refused), .hw_reset(hw_reset));

  // 40 MHz core clock.
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  // One-cycle pulses are counted where they stand.
  always @(posedge ref_clk)
  begin
    n_start += (op_start === 1'b1);
    n_ref   += (cmd_refused === 1'b1);
    n_hw    += (hw_reset === 1'b1);
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // A frame, then time for the select rise to be synced and decoded.
  task automatic send(input logic [47:0] b, input int n, input bit w = 1'b0);
    host.frame(b, n, w);
    repeat (8) @(negedge ref_clk);
  endtask : send

  // Write enable first, as the register write, program and erase commands need it.
  task automatic wsend(input logic [47:0] b, input int n);
    send({8'h06, 40'h0}, 1);
    send(b, n);
  endtask : wsend

  // End the running array operation.
  task automatic finish(input logic fail);
    @(negedge ref_clk);
    op_done = 1'b1;
    op_fail = fail;
    @(negedge ref_clk);
    op_done = 1'b0;
    op_fail = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : finish

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_errors();
    wsend({8'hD8, 32'h0010_0000, 8'h0}, 5);
    chk("erase start", 1, n_start);
    chk("erase kind", sfsp_pkg::SF_K_ERASE, op_kind);
    chk("erase addr", 32'h0010_0000, op_addr);
    chk("busy", 1, status_reg1[0]);
    finish(1'b0);
    chk("done idle", 0, status_reg1 & 8'h61);
    wsend({8'hD8, 32'h0010_0000, 8'h0}, 5);
    finish(1'b1);
    chk("erase error", 8'h21, status_reg1 & 8'h61);
    wsend({8'h02, 32'h0000_0100, 8'hA5}, 6);
    chk("blocked start", 2, n_start);
    send({8'hD0, 32'h0010_0000, 8'h0}, 5);
    chk("eval kind", sfsp_pkg::SF_K_EVAL, op_kind);
    finish(1'b0);
    chk("eval ok", 1, ees_ok);
    send({8'h30, 40'h0}, 1);
    chk("cleared", 0, status_reg1 & 8'h61);
    sect_prot = 1'b1;
    wsend({8'h02, 32'h0000_0100, 8'hA5}, 6);
    sect_prot = 1'b0;
    chk("prog error", 8'h41, status_reg1 & 8'h61);
    send({8'h30, 40'h0}, 1);
  endtask : t_errors

  task automatic t_small_erase();
    i = n_start;
    wsend({8'h20, 32'h0000_1000, 8'h0}, 5);
    chk("small start", i + 1, n_start);
    chk("small kind", sfsp_pkg::SF_K_ER4K, op_kind);
    finish(1'b0);
    wsend({8'h20, 32'h0100_0000, 8'h0}, 5);
    chk("small outside", i + 1, n_start);
  endtask : t_small_erase

  task automatic t_legacy();
    logic [7:0] ops [9] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h3B, 8'h6B, 8'h32, 8'h0D, 8'hBD};
    foreach (ops[k])
      send({ops[k], 40'h0}, 1);
    chk("refused", 9, n_ref);
  endtask : t_legacy

  task automatic t_freeze();
    wsend({8'h01, 8'h1C, 32'h0}, 2);
    chk("one byte bp", 8'h1C, status_reg1 & 8'h1C);
    chk("one byte cfg", 0, config_reg1);
    wsend({8'h01, 8'h1C, 8'h01, 24'h0}, 3);
    chk("freeze", 1, config_reg1[0]);
    wsend({8'h01, 8'h00, 32'h0}, 2);
    chk("frozen bp", 8'h1C, status_reg1 & 8'h1C);
    wsend({8'h42, 32'h0000_0010, 8'h5A}, 6);
    chk("otp frozen", 8'h41, status_reg1 & 8'h61);
    send({8'h30, 40'h0}, 1);
  endtask : t_freeze

  task automatic t_pin_reset();
    host.pin_reset();
    repeat (6) @(negedge ref_clk);
    chk("reset off", 0, n_hw);
    wsend({8'h71, 32'h0080_0002, 8'h03}, 6);
    chk("quad", 1, quad_mode);
    wsend({8'h71, 32'h0080_0003, 8'h25}, 6);
    chk("latency", 5, read_latency);
    host.pin_reset();
    repeat (6) @(negedge ref_clk);
    chk("pin reset", 1, n_hw);
    chk("cfg1 after", 0, config_reg1);
    chk("cfg2 after", 8'h08, config_reg2);
  endtask : t_pin_reset

  task automatic t_wide();
    wsend({8'h71, 32'h0080_0002, 8'h02}, 6);
    chk("quad again", 1, quad_mode);
    wsend({8'h71, 32'h0080_0003, 8'h48}, 6);
    chk("wide mode", 1, four_bit_mode);
    send({8'h06, 40'h0}, 1, 1'b1);
    chk("wide wren", 1, status_reg1[1]);
    send({8'hB9, 40'h0}, 1, 1'b1);
    chk("sleep", 1, dpd_active);
    send({8'hAB, 40'h0}, 1, 1'b1);
    chk("wake", 0, dpd_active);
  endtask : t_wide

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial
  begin
    {op_done, op_fail, sect_prot, arst_n} = 4'h0;
    {mismatches, n_compared, n_start, n_ref, n_hw} = '0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("status reset", 0, status_reg1);
    chk("cfg2 reset", 8'h08, config_reg2);
    t_errors();
    t_small_erase();
    t_legacy();
    t_freeze();
    t_pin_reset();
    t_wide();
    test_done();
  end

  // All scenarios fit well inside 200 us.
  initial
  begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule : spi_flash_status_protect_logic_tb
